// ### rtl/vdac_consts.svh
`ifndef VDAC_CONSTS_SVH
`define VDAC_CONSTS_SVH

// Register byte offsets on the APB slave
`define VDAC_CTRL_OFS       12'h000
`define VDAC_STATUS_OFS     12'h004

// Control register field positions
`define VDAC_CTRL_FT_BIT    0
`define VDAC_CTRL_PMASK_LO  8
`define VDAC_CTRL_PMASK_HI  15
`define VDAC_CTRL_CMASK_LO  16
`define VDAC_CTRL_CMASK_HI  19
`define VDAC_CTRL_RESET     32'h000FFF00
`define VDAC_CTRL_WMASK     32'h000FFF01

// Control enable mask bit order
`define VDAC_CM_SYNC        0
`define VDAC_CM_BLANK       1
`define VDAC_CM_FORCE       2
`define VDAC_CM_BRIGHT      3

// Status register field positions
`define VDAC_ST_LEVEL_HI    9
`define VDAC_ST_MODE_BIT    16
`define VDAC_ST_SEL_LO      20
`define VDAC_ST_SEL_HI      23

// Output levels in LSB units of the true output, sync tip at zero
`define VDAC_SYNC_LVL       10'h000
`define VDAC_BLANK_LVL      10'h070
`define VDAC_SETUP_LVL      10'h014
`define VDAC_BRIGHT_LVL     10'h01A
`define VDAC_MAX_LVL        10'h19D
`define VDAC_FULL_CODE      8'hFF
`define VDAC_SEG_STEP       10'h010

`endif

// ### rtl/vdac_pkg.sv
package vdac_pkg;

	// Which video source sets the output level, in priority order
	typedef enum logic [3:0] {
		VDAC_SEL_SYNC  = 4'b0001,
		VDAC_SEL_BLANK = 4'b0010,
		VDAC_SEL_WHITE = 4'b0100,
		VDAC_SEL_DATA  = 4'b1000
	} vdac_sel_type;

	typedef logic [9:0] vdac_level_type;

endpackage

// ### rtl/vdac_seg_if.sv
`timescale 1ns/1ps
`default_nettype none

// Pixel code in, segmented weights out
interface vdac_seg_if;
	logic [7:0]  code;
	logic [14:0] therm;
	logic [9:0]  units;

	modport prod (input code, output therm, output units);
	modport cons (output code, input therm, input units);
endinterface

`default_nettype wire

// ### rtl/vdac_seg.sv
`timescale 1ns/1ps
`default_nettype none
`include "vdac_consts.svh"

// Segmented weighting: upper nibble as thermometer, lower nibble binary
module vdac_seg (
	vdac_seg_if.prod seg
);
	import vdac_pkg::*;

	// One segment per step of the upper nibble
	genvar i;
	generate
		for (i = 0; i < 15; i++) begin : g_therm
			assign seg.therm[i] = (seg.code[7:4] > 4'(i));
		end
	endgenerate

	// Each lit segment is worth sixteen low-order steps
	always_comb begin
		logic [9:0] acc;
		acc = 10'({6'h00, seg.code[3:0]});
		for (int k = 0; k < 15; k++) begin
			if (seg.therm[k]) begin
				acc = acc + `VDAC_SEG_STEP;
			end
		end
		seg.units = acc;
	end
endmodule

`default_nettype wire

// ### rtl/vdac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vdac_consts.svh"

module vdac_top (
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	input  wire logic [7:0]               pixel_code,
	input  wire logic                     sync_in,
	input  wire logic                     blank_in,
	input  wire logic                     force_full_scale,
	input  wire logic                     bright_boost,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output var  logic [31:0]              prdata,
	output var  logic                     pready,
	output var  logic                     pslverr,
	output var  vdac_pkg::vdac_level_type out_true,
	output var  vdac_pkg::vdac_level_type out_comp
);
	import vdac_pkg::*;

	logic [31:0]    ctrl_q, ctrl_d;
	logic [31:0]    prdata_q, prdata_d;
	logic           pready_q, pready_d;
	logic           pslverr_q, pslverr_d;
	logic           ft;
	logic [7:0]     pix_eff;
	logic           sync_eff, blank_eff, force_eff, bright_eff;
	vdac_sel_type   sel_live, sel_q;
	vdac_level_type lvl_live, lvl_q, lvl_d;
	vdac_sel_type   sel_d;
	logic           setup_ph, access_ph, addr_ok;

	vdac_seg_if seg_bus ();

	vdac_seg u_seg (
		.seg (seg_bus)
	);

	assign ft = ctrl_q[`VDAC_CTRL_FT_BIT];

	// Masked inputs stand in for open pins, which read as low
	assign pix_eff    = pixel_code & ctrl_q[`VDAC_CTRL_PMASK_HI:`VDAC_CTRL_PMASK_LO];
	assign sync_eff   = sync_in & ctrl_q[`VDAC_CTRL_CMASK_LO + `VDAC_CM_SYNC];
	assign blank_eff  = blank_in & ctrl_q[`VDAC_CTRL_CMASK_LO + `VDAC_CM_BLANK];
	assign force_eff  = force_full_scale & ctrl_q[`VDAC_CTRL_CMASK_LO + `VDAC_CM_FORCE];
	assign bright_eff = bright_boost & ctrl_q[`VDAC_CTRL_CMASK_LO + `VDAC_CM_BRIGHT];

	// Force full scale replaces the code ahead of the weighting network
	assign seg_bus.code = force_eff ? `VDAC_FULL_CODE : pix_eff;

	// Priority decode of the video controls
	always_comb begin
		if (sync_eff) begin
			sel_live = VDAC_SEL_SYNC;
		end else if (blank_eff) begin
			sel_live = VDAC_SEL_BLANK;
		end else if (force_eff) begin
			sel_live = VDAC_SEL_WHITE;
		end else begin
			sel_live = VDAC_SEL_DATA;
		end
	end

	// Level of the true output for the live inputs
	always_comb begin
		unique case (sel_live)
			VDAC_SEL_SYNC: begin
				lvl_live = `VDAC_SYNC_LVL;
			end
			VDAC_SEL_BLANK: begin
				lvl_live = `VDAC_BLANK_LVL;
			end
			VDAC_SEL_WHITE, VDAC_SEL_DATA: begin
				// Segmented weight on top of blank plus setup pedestal
				lvl_live = `VDAC_BLANK_LVL + `VDAC_SETUP_LVL + seg_bus.units;
				if (bright_eff) begin
					lvl_live = lvl_live + `VDAC_BRIGHT_LVL;
				end
			end
			default: begin
				lvl_live = `VDAC_BLANK_LVL;
			end
		endcase
	end

	// Capture path: decoded level and source latched every edge
	always_comb begin
		lvl_d = lvl_live;
		sel_d = sel_live;
	end

	// No reset here: the level is unknown until the first clock edge
	always_ff @(posedge clk) begin
		lvl_q <= lvl_d;
		sel_q <= sel_d;
	end

	// Feedthrough bypasses the register; in that mode outputs are not from a flop
	always_comb begin
		out_true = ft ? lvl_live : lvl_q;
		out_comp = `VDAC_MAX_LVL - out_true;
	end

	// APB phase decode
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign addr_ok   = (paddr == `VDAC_CTRL_OFS) || (paddr == `VDAC_STATUS_OFS);

	// Register file and answer; one access cycle, no wait states
	always_comb begin
		ctrl_d    = ctrl_q;
		prdata_d  = 32'h00000000;
		pready_d  = setup_ph;
		pslverr_d = setup_ph & ~addr_ok;
		// Feedthrough is a static setting, changed only by a control write or by reset
		if (access_ph && pwrite && paddr == `VDAC_CTRL_OFS) begin
			ctrl_d = pwdata & `VDAC_CTRL_WMASK;
		end
		if (setup_ph && !pwrite) begin
			if (paddr == `VDAC_CTRL_OFS) begin
				prdata_d = ctrl_q;
			end else if (paddr == `VDAC_STATUS_OFS) begin
				prdata_d[`VDAC_ST_LEVEL_HI:0]              = out_true;
				prdata_d[`VDAC_ST_MODE_BIT]                = ft;
				prdata_d[`VDAC_ST_SEL_HI:`VDAC_ST_SEL_LO]  = ft ? sel_live : sel_q;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q    <= `VDAC_CTRL_RESET;
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// Checks on the level path and the APB answer
	reg_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!ft && $past(!ft)) |-> (out_true == $past(lvl_live)))
		else $error("registered output does not match captured inputs");

	feed_track_a: assert property (@(posedge clk) disable iff (!reset_n)
		ft |-> (out_true == lvl_live))
		else $error("feedthrough output does not track inputs");

	ft_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		!(access_ph && pwrite && paddr == `VDAC_CTRL_OFS) |=> $stable(ft))
		else $error("feedthrough changed without a control write");

	sync_level_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!ft && sync_eff) ##1 !ft |-> (out_true == `VDAC_SYNC_LVL)
			&& (out_comp == `VDAC_MAX_LVL))
		else $error("sync did not give the sync level");

	blank_level_a: assert property (@(posedge clk) disable iff (!reset_n)
		(ft && !sync_eff && blank_eff) |-> (out_true == `VDAC_BLANK_LVL))
		else $error("blank did not give the blank level");

	white_level_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!sync_eff && !blank_eff && force_eff && !bright_eff)
			|-> (lvl_live == `VDAC_BLANK_LVL + `VDAC_SETUP_LVL + 10'h0FF))
		else $error("force full scale did not give reference white");

	bright_add_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!sync_eff && !blank_eff && bright_eff)
			|-> (lvl_live == `VDAC_BLANK_LVL + `VDAC_SETUP_LVL + seg_bus.units + `VDAC_BRIGHT_LVL))
		else $error("bright did not add its step");

	pixel_mask_a: assert property (@(posedge clk) disable iff (!reset_n)
		(ctrl_q[`VDAC_CTRL_PMASK_HI:`VDAC_CTRL_PMASK_LO] == 8'h00 && !force_eff)
			|-> (seg_bus.units == 10'h000))
		else $error("masked pixel bits still contribute");

	comp_pair_a: assert property (@(posedge clk) disable iff (!reset_n)
		(out_true + out_comp) == `VDAC_MAX_LVL)
		else $error("outputs are not complementary");

	seg_weight_a: assert property (@(posedge clk) disable iff (!reset_n)
		($countones(seg_bus.therm) == int'(seg_bus.code[7:4]))
			&& (seg_bus.units == 10'(seg_bus.code)))
		else $error("segmented weighting is wrong");

	apb_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
		setup_ph |=> pready)
		else $error("access phase did not answer at once");

	// Main scenarios
	sync_seen_c:   cover property (@(posedge clk) disable iff (!reset_n) !ft && sync_eff ##1 !sync_eff);
	white_boost_c: cover property (@(posedge clk) disable iff (!reset_n) force_eff && bright_eff && !blank_eff);
	ft_mode_c:     cover property (@(posedge clk) disable iff (!reset_n) !ft ##1 ft);
	bad_addr_c:    cover property (@(posedge clk) disable iff (!reset_n) pready && pslverr);
endmodule

`default_nettype wire

// ### tb/vdac_gfx_model.sv
`timescale 1ns/1ps
`default_nettype none

// Pixel source: one pixel and its controls each clock, launched just after the edge
module vdac_gfx_model (
	input  wire logic        clk,
	input  wire logic [11:0] word,
	output var  logic [7:0]  pixel_code,
	output var  logic        sync_in,
	output var  logic        blank_in,
	output var  logic        force_full_scale,
	output var  logic        bright_boost
);
	// Defined from time zero so nothing floats before the first pixel
	initial {bright_boost, force_full_scale, blank_in, sync_in, pixel_code} = 12'h000;

	// Never touches feedthrough, which stays a static setting
	always @(posedge clk) begin
		{bright_boost, force_full_scale, blank_in, sync_in, pixel_code} <= word;
	end
endmodule

`default_nettype wire

// ### tb/test_video_dac_input_register.sv
`timescale 1ns/1ps
`default_nettype none

module test_video_dac_input_register;
	logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000, word = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd, seed = 32'h00005D9C;
	logic        pready, pslverr, er;
	logic [7:0]  pixel_code;
	logic        sync_in, blank_in, force_full_scale, bright_boost;
	logic [9:0]  out_true, out_comp;
	int          fails = 0, checks = 0;
	logic [31:0] cfg [5] = '{32'h000FFF00, 32'h000F0F00, 32'h0000FF00, 32'hFFFFFFFF, 32'h000F0000};
	logic [11:0] hw [3] = '{12'h100, 12'hC00, 12'h080};

	vdac_top i_dut (.clk(clk), .reset_n(reset_n), .pixel_code(pixel_code), .sync_in(sync_in),
		.blank_in(blank_in), .force_full_scale(force_full_scale), .bright_boost(bright_boost),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .out_true(out_true), .out_comp(out_comp));
	vdac_gfx_model i_gfx (.clk(clk), .word(word), .pixel_code(pixel_code), .sync_in(sync_in),
		.blank_in(blank_in), .force_full_scale(force_full_scale), .bright_boost(bright_boost));

	initial forever #5 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Level from masked inputs: sync, then blank, then white or data plus boost
	function automatic logic [9:0] lvl(logic [11:0] v, logic [31:0] c);
		logic [7:0] p;
		logic [3:0] m;
		p = v[7:0] & c[15:8];
		m = v[11:8] & c[19:16];
		if (m[0]) return 10'h000;
		if (m[1]) return 10'h070;
		if (m[2]) p = 8'hFF;
		return 10'h084 + {2'b00, p} + (m[3] ? 10'h01A : 10'h000);
	endfunction

	function automatic logic [3:0] src(logic [11:0] v);
		return v[8] ? 4'h1 : v[9] ? 4'h2 : v[10] ? 4'h4 : 4'h8;
	endfunction

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_lvl(input logic [9:0] got, input logic [9:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t level got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer; answer is taken at the edge that sees pready high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		if (n >= 50) fails++;
		psel <= 0;
		penable <= 0;
	endtask

	// Random pixels; registered output lags one edge, feedthrough follows at once
	task automatic run(input logic [31:0] c);
		logic [9:0]  e;
		logic [31:0] r;
		for (int i = 0; i < 150; i++) begin
			r = rnd();
			@(posedge clk);
			word <= r[11:0];
			@(negedge clk);
			if (c[0]) e = lvl({bright_boost, force_full_scale, blank_in, sync_in, pixel_code}, c);
			if (i > 0 || c[0]) begin
				cmp_lvl(out_true, e);
				cmp_lvl(out_comp, 10'h19D - e);
			end
			if (!c[0]) e = lvl({bright_boost, force_full_scale, blank_in, sync_in, pixel_code}, c);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1;
		apb(0, 12'h000, 0);
		cmp_word(rd, 32'h000FFF00);
		apb(0, 12'h008, 0);
		cmp_word({rd[30:0], er}, 32'h00000001);
		apb(1, 12'h004, 32'hFFFFFFFF);
		cmp_word({31'h0, er}, 32'h00000000);
		for (int k = 0; k < 5; k++) begin
			apb(1, 12'h000, cfg[k]);
			apb(0, 12'h000, 0);
			cmp_word(rd, cfg[k] & 32'h000FFF01);
			run(rd);
		end
		// Held corner pixels read back through status in registered mode
		apb(1, 12'h000, 32'h000FFF00);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			word <= hw[k];
			repeat (3) @(posedge clk);
			apb(0, 12'h004, 0);
			cmp_word(rd, {8'h00, src(hw[k]), 10'h000, lvl(hw[k], 32'h000FFF00)});
		end
		// Mid-run reset puts the control word back to its reset value
		apb(1, 12'h000, 32'h00000001);
		@(posedge clk);
		reset_n <= 0;
		repeat (3) @(posedge clk);
		reset_n <= 1;
		apb(0, 12'h000, 0);
		cmp_word(rd, 32'h000FFF00);
		wrap_up();
	end

	initial begin
		#100000;
		fails++;
		wrap_up();
	end
endmodule

`default_nettype wire
